//--- common/pmiu_cfg.svh
// Purpose: constants of the power mode and interrupt unit
// Assumes: 200 MHz system clock
// Notes:   register indices follow the serial register map
`ifndef PMIU_CFG_SVH
`define PMIU_CFG_SVH
`define PMIU_ADDR_W            4
`define PMIU_REG_SYSCTL        4'h2
`define PMIU_REG_IFLAG         4'h8
`define PMIU_REG_IMASK         4'h9
`define PMIU_REG_RSTAT         4'hD
// interrupt flag / mask bit positions
`define PMIU_B_WAKE            0
`define PMIU_B_HALL            1
`define PMIU_B_LINE            2
`define PMIU_B_HTEMP           3
`define PMIU_B_LVOLT           4
`define PMIU_B_HVOLT           5
`define PMIU_B_PSF             6
`define PMIU_B_HTRD            7
// system control bits
`define PMIU_C_POWER_STAGE_ON            0
`define PMIU_C_STOP            1
`define PMIU_C_SLEEP           2
// reset status wake bits
`define PMIU_R_LINWK           0
`define PMIU_R_WKWK            1
`define PMIU_IMASK_RST         8'h00
`define PMIU_CLK_MHZ           200
`define PMIU_NORMREQ_MS        80
`define PMIU_WAKE_DOM_NS       150000
`define PMIU_RSTOUT_US         1250
`endif

//--- common/pmiu_pkg.sv
// Purpose: types of the power mode and interrupt unit
// Assumes: nothing
// Notes:   none
`default_nettype none
package pmiu_pkg;
  typedef enum logic [2:0] {
    PMIU_RESET   = 3'b000,
    PMIU_NORMREQ = 3'b001,
    PMIU_NORMAL  = 3'b010,
    PMIU_STOP    = 3'b011,
    PMIU_SLEEP   = 3'b100
  } pmiu_mode_t;
  typedef struct packed {
    logic       wr;
    logic [3:0] addr;
    logic [7:0] data;
  } pmiu_req_t;
  typedef struct packed {
    logic low_voltage;
    logic high_voltage;
    logic high_temp;
    logic power_stage_fail;
  } pmiu_analog_t;
endpackage : pmiu_pkg
`default_nettype wire

//--- hw/pmiu_edge.sv
// Purpose: edge detector on a synchronous level
// Assumes: input already synchronous to the clock
// Notes:   arm low suppresses edges and tracks the level
`default_nettype none
module pmiu_edge (
  input  wire logic mclk_in,
  input  wire logic sys_rst_in,
  input  wire logic arm_in,
  input  wire logic level_in,
  output logic      edge_out
);
  logic prev;
  always_ff @(posedge mclk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
      prev <= 1'b0;
    else
      prev <= level_in;
  end
  assign edge_out = arm_in & (prev ^ level_in);
endmodule : pmiu_edge
`default_nettype wire

//--- hw/pmiu_timer.sv
// Purpose: run counter with terminal flag
// Assumes: clear restarts the count
// Notes:   done stays high while run is held after terminal count
`default_nettype none
module pmiu_timer #(
  parameter int unsigned LIMIT = 16
) (
  input  wire logic mclk_in,
  input  wire logic sys_rst_in,
  input  wire logic run_in,
  output logic      done_out
);
  logic [31:0] cnt;
  always_ff @(posedge mclk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
      cnt <= 32'h0;
    else if (!run_in)
      cnt <= 32'h0;
    else if (cnt < LIMIT)
      cnt <= cnt + 32'h1;
  end
  assign done_out = run_in && (cnt >= LIMIT);
endmodule : pmiu_timer
`default_nettype wire

//--- hw/pmiu_top.sv
// Purpose: mode control and interrupt logic of the analog die
// Assumes: register port and pins synchronous to mclk_in
// Notes:   reset of the die is sys_rst_in; sleep wake replays it for SYSCTL, IMASK and the flags, not the wake flags
`default_nettype none
`include "pmiu_cfg.svh"
module pmiu_top #(
  parameter int unsigned NORMREQ_CYC = `PMIU_NORMREQ_MS * 1000 * 1000 / 5,
  parameter int unsigned RSTOUT_CYC  = `PMIU_RSTOUT_US * `PMIU_CLK_MHZ
) (
  input  wire logic                  mclk_in,
  input  wire logic                  sys_rst_in,
  input  wire pmiu_pkg::pmiu_req_t   req_in,
  input  wire logic                  req_valid_in,
  output logic [7:0]                 rdata_out,
  input  wire pmiu_pkg::pmiu_analog_t analog_in,
  input  wire logic                  bus_dominant_in,
  input  wire logic                  wake_input_in,
  input  wire logic                  hall_input_in,
  input  wire logic                  hall_gp_or_2pin_in,
  input  wire logic                  watchdog_enable_in,
  output logic                       irq_pulse_out,
  output logic                       rst_n_out,
  output logic                       vdd_on_out,
  output logic                       stages_enable_out,
  output logic                       bus_enable_out,
  output logic                       bus_recessive_out,
  output logic                       watchdog_run_out,
  output logic                       high_temp_reset_disable_out,
  output pmiu_pkg::pmiu_mode_t       mode_out
);
  import pmiu_pkg::*;

  localparam int unsigned WAKE_DOM_CYC =
    (`PMIU_WAKE_DOM_NS * `PMIU_CLK_MHZ + 999) / 1000;

  pmiu_mode_t mode;
  pmiu_mode_t next_mode;
  logic [7:0] interrupt_flags;
  logic [7:0] next_flags;
  logic [7:0] imask;
  logic [2:0] sysctl;
  logic [1:0] rstat;
  logic [7:0] prev_pend;
  logic       wake_soft_rst;
  logic       run;
  logic       low_pw;
  logic       wr_flag;
  logic       wr_mask;
  logic       wr_ctl;
  logic       wr_rst;
  logic       wake_edge;
  logic       hall_edge;
  logic       dom_long;
  logic       dom_seen;
  logic       bus_rise;
  logic       bus_prev;
  logic       normreq_to;
  logic       rst_done;
  logic       blk_rst;

  // a sleep wake resets control, mask and flag registers like power-on
  assign blk_rst = sys_rst_in | wake_soft_rst;
  assign run     = (mode == PMIU_NORMAL);
  assign low_pw  = (mode == PMIU_STOP) || (mode == PMIU_SLEEP);
  assign wr_flag = req_valid_in && req_in.wr && (req_in.addr == `PMIU_REG_IFLAG);
  assign wr_mask = req_valid_in && req_in.wr && (req_in.addr == `PMIU_REG_IMASK);
  assign wr_ctl  = req_valid_in && req_in.wr && (req_in.addr == `PMIU_REG_SYSCTL);
  assign wr_rst  = req_valid_in && req_in.wr && (req_in.addr == `PMIU_REG_RSTAT);

  pmiu_edge u_wake_edge (
    .mclk_in    (mclk_in),
    .sys_rst_in (sys_rst_in),
    .arm_in     (mode != PMIU_RESET),
    .level_in   (wake_input_in),
    .edge_out   (wake_edge)
  );

  pmiu_edge u_hall_edge (
    .mclk_in    (mclk_in),
    .sys_rst_in (sys_rst_in),
    .arm_in     (run && hall_gp_or_2pin_in),
    .level_in   (hall_input_in),
    .edge_out   (hall_edge)
  );

  pmiu_timer #(.LIMIT(WAKE_DOM_CYC)) u_dom_timer (
    .mclk_in    (mclk_in),
    .sys_rst_in (sys_rst_in),
    .run_in     (bus_dominant_in && low_pw),
    .done_out   (dom_long)
  );

  pmiu_timer #(.LIMIT(NORMREQ_CYC)) u_normreq_timer (
    .mclk_in    (mclk_in),
    .sys_rst_in (sys_rst_in),
    .run_in     (mode == PMIU_NORMREQ),
    .done_out   (normreq_to)
  );

  pmiu_timer #(.LIMIT(RSTOUT_CYC)) u_rst_timer (
    .mclk_in    (mclk_in),
    .sys_rst_in (sys_rst_in),
    .run_in     (mode == PMIU_RESET),
    .done_out   (rst_done)
  );

  // bus wake qualifies a recessive edge after long dominance
  always_ff @(posedge mclk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      bus_prev <= 1'b0;
      dom_seen <= 1'b0;
    end
    else
    begin
      bus_prev <= bus_dominant_in;
      if (!low_pw || bus_rise)
        dom_seen <= 1'b0;
      else if (dom_long)
        dom_seen <= 1'b1;
    end
  end
  assign bus_rise = bus_prev && !bus_dominant_in && dom_seen;

  always_comb
  begin
    next_mode     = mode;
    wake_soft_rst = 1'b0;
    case (mode)
      PMIU_RESET:
        if (rst_done)
          next_mode = PMIU_NORMREQ;
      PMIU_NORMREQ:
        if (sysctl[`PMIU_C_POWER_STAGE_ON])
          next_mode = PMIU_NORMAL;
        else if (normreq_to)
          next_mode = PMIU_SLEEP;
      PMIU_NORMAL:
        if (sysctl[`PMIU_C_SLEEP])
          next_mode = PMIU_SLEEP;
        else if (sysctl[`PMIU_C_STOP])
          next_mode = PMIU_STOP;
      PMIU_STOP:
        if (sysctl[`PMIU_C_POWER_STAGE_ON] && !sysctl[`PMIU_C_STOP])
          next_mode = PMIU_NORMAL;
      PMIU_SLEEP:
        if (bus_rise || wake_edge)
        begin
          next_mode     = PMIU_RESET;
          wake_soft_rst = 1'b1;
        end
      default:
        next_mode = PMIU_RESET;
    endcase
  end

  always_ff @(posedge mclk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
      mode <= PMIU_RESET;
    else
      mode <= next_mode;
  end

  // system control; stop bit drops on a stop wake so the controller resumes
  always_ff @(posedge mclk_in or posedge blk_rst)
  begin
    if (blk_rst)
      sysctl <= 3'b000;
    else if (wr_ctl)
      sysctl <= req_in.data[2:0];
    else if (mode == PMIU_STOP && ((bus_rise && imask[`PMIU_B_LINE])
             || (wake_edge && imask[`PMIU_B_WAKE])))
      sysctl[`PMIU_C_STOP] <= 1'b0;
  end

  always_ff @(posedge mclk_in or posedge blk_rst)
  begin
    if (blk_rst)
      imask <= `PMIU_IMASK_RST;
    else if (wr_mask)
      imask <= req_in.data;
  end

  // wake flags survive the sleep-wake reset; power-on or writing a one to the bit clears them
  always_ff @(posedge mclk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
      rstat <= 2'b00;
    else
    begin
      if (mode == PMIU_SLEEP && bus_rise)
        rstat[`PMIU_R_LINWK] <= 1'b1;
      else if (wr_rst && req_in.data[`PMIU_R_LINWK])
        rstat[`PMIU_R_LINWK] <= 1'b0;
      if (mode == PMIU_SLEEP && wake_edge)
        rstat[`PMIU_R_WKWK] <= 1'b1;
      else if (wr_rst && req_in.data[`PMIU_R_WKWK])
        rstat[`PMIU_R_WKWK] <= 1'b0;
    end
  end

  always_comb
  begin
    next_flags = interrupt_flags;
    if (wr_flag)
      next_flags = interrupt_flags & ~req_in.data;
    next_flags[`PMIU_B_HTRD] = 1'b0;
    if (run && wake_edge)
      next_flags[`PMIU_B_WAKE] = 1'b1;
    if (mode == PMIU_STOP && wake_edge && imask[`PMIU_B_WAKE])
      next_flags[`PMIU_B_WAKE] = 1'b1;
    if (hall_edge)
      next_flags[`PMIU_B_HALL] = 1'b1;
    if (mode == PMIU_STOP && bus_rise && imask[`PMIU_B_LINE])
      next_flags[`PMIU_B_LINE] = 1'b1;
    if (!low_pw && analog_in.high_temp)
      next_flags[`PMIU_B_HTEMP] = 1'b1;
    if (!low_pw && analog_in.low_voltage)
      next_flags[`PMIU_B_LVOLT] = 1'b1;
    if (!low_pw && analog_in.high_voltage)
      next_flags[`PMIU_B_HVOLT] = 1'b1;
    if (!low_pw && analog_in.power_stage_fail)
      next_flags[`PMIU_B_PSF] = 1'b1;
  end

  always_ff @(posedge mclk_in or posedge blk_rst)
  begin
    if (blk_rst)
      interrupt_flags <= 8'h00;
    else
      interrupt_flags <= next_flags;
  end

  // one-cycle pulse when any enabled flag rises
  always_ff @(posedge mclk_in or posedge blk_rst)
  begin
    if (blk_rst)
    begin
      prev_pend     <= 8'h00;
      irq_pulse_out <= 1'b0;
    end
    else
    begin
      prev_pend     <= interrupt_flags & imask & 8'h7F;
      irq_pulse_out <= |((interrupt_flags & imask & 8'h7F) & ~prev_pend);
    end
  end

  always_ff @(posedge mclk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
      rdata_out <= 8'h00;
    else if (req_valid_in && !req_in.wr)
      case (req_in.addr)
        `PMIU_REG_IFLAG:  rdata_out <= interrupt_flags;
        `PMIU_REG_IMASK:  rdata_out <= imask;
        `PMIU_REG_SYSCTL: rdata_out <= {5'h00, sysctl};
        `PMIU_REG_RSTAT:  rdata_out <= {6'h00, rstat};
        default:          rdata_out <= 8'h00;
      endcase
  end

  always_comb
  begin
    rst_n_out         = !(mode == PMIU_RESET || mode == PMIU_SLEEP);
    vdd_on_out        = (mode != PMIU_SLEEP);
    stages_enable_out = run;
    bus_enable_out    = run;
    bus_recessive_out = low_pw;
    watchdog_run_out  = run && watchdog_enable_in;
  end
  assign high_temp_reset_disable_out = imask[`PMIU_B_HTRD];
  assign mode_out = mode;
endmodule : pmiu_top
`default_nettype wire

//--- tb/pmiu_chk.sv
// Purpose: port checker of the power mode and interrupt unit
// Assumes: mode outputs follow the mode register directly
// Notes:   bound into every pmiu_top
`default_nettype none
module pmiu_chk
  import pmiu_pkg::*;
#(
  parameter int unsigned NORMREQ_CYC = 16,
  parameter int unsigned RSTOUT_CYC  = 16
) (
  input wire logic                 mclk_in,
  input wire logic                 sys_rst_in,
  input wire logic                 watchdog_enable_in,
  input wire logic                 irq_pulse_out,
  input wire logic                 rst_n_out,
  input wire logic                 vdd_on_out,
  input wire logic                 stages_enable_out,
  input wire logic                 bus_enable_out,
  input wire logic                 bus_recessive_out,
  input wire logic                 watchdog_run_out,
  input wire pmiu_pkg::pmiu_mode_t mode_out
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned NREQ_MAX = NORMREQ_CYC + 3;
  localparam int unsigned RST_MAX  = RSTOUT_CYC + 3;
  int unsigned nreq_cnt;
  int unsigned rst_cnt;
  // cycles spent so far in the waiting modes
  always_ff @(posedge mclk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      nreq_cnt <= 0;
      rst_cnt  <= 0;
    end
    else
    begin
      nreq_cnt <= (mode_out == PMIU_NORMREQ) ? nreq_cnt + 1 : 0;
      rst_cnt  <= (mode_out == PMIU_RESET) ? rst_cnt + 1 : 0;
    end
  end
  default clocking dc @(posedge mclk_in); endclocking
  default disable iff (sys_rst_in);
  chk_irq_one_cycle: assert property (irq_pulse_out |=> !irq_pulse_out)
    else $error("interrupt pulse wider than one cycle");
  chk_reset_quiet: assert property (mode_out == PMIU_RESET |-> !irq_pulse_out && !rst_n_out)
    else $error("interrupt or reset release in reset mode");
  chk_sleep_supply_off: assert property (mode_out == PMIU_SLEEP |-> !rst_n_out && !vdd_on_out)
    else $error("controller supplied or released in sleep");
  chk_normal_enables: assert property (mode_out == PMIU_NORMAL |-> stages_enable_out && bus_enable_out)
    else $error("stages or bus off in normal mode");
  chk_stages_only_normal: assert property (stages_enable_out || bus_enable_out |-> mode_out == PMIU_NORMAL)
    else $error("stages or bus on outside normal mode");
  chk_low_power_bus: assert property ((mode_out == PMIU_STOP || mode_out == PMIU_SLEEP)
    |-> bus_recessive_out && !watchdog_run_out)
    else $error("bus not recessive or watchdog running in low power");
  chk_watchdog_gate: assert property (watchdog_run_out |-> watchdog_enable_in)
    else $error("watchdog running while disabled");
  chk_normreq_bounded: assert property (nreq_cnt <= NREQ_MAX)
    else $error("normal request mode outlasts its timeout");
  chk_reset_bounded: assert property (rst_cnt <= RST_MAX)
    else $error("reset mode outlasts reset output time");
  cover property (mode_out == PMIU_STOP);
  cover property (mode_out == PMIU_SLEEP);
  cover property (irq_pulse_out);
endmodule : pmiu_chk
bind pmiu_top pmiu_chk #(.NORMREQ_CYC(NORMREQ_CYC), .RSTOUT_CYC(RSTOUT_CYC)) i_pmiu_chk (
  .mclk_in, .sys_rst_in, .watchdog_enable_in, .irq_pulse_out, .rst_n_out, .vdd_on_out,
  .stages_enable_out, .bus_enable_out, .bus_recessive_out, .watchdog_run_out, .mode_out);
`default_nettype wire

//--- tb/pmiu_ctrl_model.sv
// Purpose: controller side of the register link
// Assumes: one request per call, strobe held over one taking edge
// Notes:   released request lines show scrambled values
`default_nettype none
module pmiu_ctrl_model
  import pmiu_pkg::*;
(
  input  wire logic           mclk_in,
  input  wire logic [7:0]     rdata_in,
  output var pmiu_pkg::pmiu_req_t req_out,
  output logic                req_valid_out
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    req_out       = '0;
    req_valid_out = 1'b0;
  end
  // software sets stop, sleep and power-stage-on bits through here
  task automatic xfer(input logic wr, input logic [3:0] a, input logic [7:0] d,
                      output logic [7:0] rd);
    @(posedge mclk_in);
    #1;
    req_out       = '{wr, a, d};
    req_valid_out = 1'b1;
    @(posedge mclk_in);
    #1;
    req_valid_out = 1'b0;
    req_out       = '{1'b0, ~a, ~d};
    @(posedge mclk_in);
    #1;
    rd = rdata_in;
  endtask : xfer
endmodule : pmiu_ctrl_model
`default_nettype wire

//--- tb/power_mode_and_interrupt_unit_test.sv
// Purpose: self-checking bench of the power mode and interrupt unit
// Assumes: shortened reset-out and normal-request counts
// Notes:   bus wake needs 30000 dominant cycles, the longest step
`default_nettype none
`include "pmiu_cfg.svh"
module power_mode_and_interrupt_unit_test import pmiu_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic         mclk_in, sys_rst_in, req_valid, bus_dom, wake, hall, hall_gp;
  logic         irq, rst_n, vdd_on, stages, bus_en;
  logic         wd_en, recess, wd_run, htrd;
  logic [7:0]   rdata, rd, v;
  logic [31:0]  seed;
  pmiu_req_t    req;
  pmiu_analog_t ana;
  pmiu_mode_t   mode;
  int           fails, total_checks, irq_count, irq_base, cyc, fb[4];

  pmiu_top #(.NORMREQ_CYC(50), .RSTOUT_CYC(10)) i_pmiu_top (
    .mclk_in, .sys_rst_in, .req_in(req), .req_valid_in(req_valid), .rdata_out(rdata),
    .analog_in(ana), .bus_dominant_in(bus_dom), .wake_input_in(wake), .hall_input_in(hall),
    .hall_gp_or_2pin_in(hall_gp), .watchdog_enable_in(wd_en), .irq_pulse_out(irq),
    .rst_n_out(rst_n), .vdd_on_out(vdd_on), .stages_enable_out(stages),
    .bus_enable_out(bus_en), .bus_recessive_out(recess), .watchdog_run_out(wd_run),
    .high_temp_reset_disable_out(htrd), .mode_out(mode));
  pmiu_ctrl_model i_pmiu_ctrl_model (.mclk_in, .rdata_in(rdata), .req_out(req),
    .req_valid_out(req_valid));

  initial
  begin
    mclk_in = 1'b0;
    forever #2.5 mclk_in = ~mclk_in;
  end
  always @(posedge mclk_in)
  begin
    cyc++;
    if (irq === 1'b1)
      irq_count++;
    if (cyc == 45000)
    begin
      fails++;
      give_verdict();
    end
  end

  function automatic logic [7:0] bit_of(input int b);
    return 8'h01 << b;
  endfunction : bit_of
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check
  task automatic acc(input logic wr, input logic [3:0] a, input logic [7:0] d);
    i_pmiu_ctrl_model.xfer(wr, a, d, rd);
  endtask : acc
  task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp);
    acc(1'b0, a, 8'h00);
    check(rd, exp);
  endtask : rd_chk
  task automatic irq_chk(input logic [7:0] exp);
    check(8'(irq_count - irq_base), exp);
  endtask : irq_chk
  task automatic step(input int n);
    repeat (n) @(posedge mclk_in);
    #1;
  endtask : step
  task automatic wait_mode(input pmiu_mode_t m);
    for (int i = 0; i < 200 && mode !== m; i++)
      step(1);
    check({5'h00, mode}, {5'h00, m});
  endtask : wait_mode
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : give_verdict

  initial
  begin
    fb = '{6, 3, 5, 4};
    seed = 32'hc855ff78;
    sys_rst_in = 1'b1;
    ana = '0;
    bus_dom = 1'b0;
    wake = 1'b0;
    hall = 1'b0;
    hall_gp = 1'b1;
    wd_en = 1'b1;
    step(5);
    sys_rst_in = 1'b0;
    wait_mode(PMIU_NORMREQ);
    rd_chk(`PMIU_REG_IMASK, `PMIU_IMASK_RST);
    acc(1'b1, `PMIU_REG_SYSCTL, bit_of(`PMIU_C_POWER_STAGE_ON));
    wait_mode(PMIU_NORMAL);
    check({7'h00, stages & bus_en}, 8'h01);
    for (int i = 0; i < 8; i++)
    begin
      v = 8'($random(seed));
      acc(1'b1, `PMIU_REG_IMASK, v);
      rd_chk(`PMIU_REG_IMASK, v);
      wd_en = v[0];
      step(1);
      check({6'h00, wd_run, htrd}, {6'h00, v[0], v[7]});
      acc(1'b1, `PMIU_REG_IFLAG, v);
      rd_chk(`PMIU_REG_IFLAG, 8'h00);
    end
    $display("test registers finished");
    acc(1'b1, `PMIU_REG_IMASK, 8'h7F);
    for (int i = 0; i < 4; i++)
    begin
      irq_base = irq_count;
      ana[i] = 1'b1;
      step(4);
      rd_chk(`PMIU_REG_IFLAG, bit_of(fb[i]));
      irq_chk(8'h01);
      acc(1'b1, `PMIU_REG_IFLAG, bit_of(fb[i]));
      rd_chk(`PMIU_REG_IFLAG, bit_of(fb[i]));
      ana[i] = 1'b0;
      acc(1'b1, `PMIU_REG_IFLAG, 8'h00);
      rd_chk(`PMIU_REG_IFLAG, bit_of(fb[i]));
      acc(1'b1, `PMIU_REG_IFLAG, bit_of(fb[i]));
      rd_chk(`PMIU_REG_IFLAG, 8'h00);
    end
    $display("test analog finished");
    acc(1'b1, `PMIU_REG_IMASK, 8'h7E);
    irq_base = irq_count;
    hall = 1'b1;
    wake = 1'b1;
    step(4);
    rd_chk(`PMIU_REG_IFLAG, 8'h03);
    irq_chk(8'h01);
    acc(1'b1, `PMIU_REG_IMASK, 8'h7F);
    step(3);
    irq_chk(8'h02);
    acc(1'b1, `PMIU_REG_IFLAG, 8'h03);
    hall_gp = 1'b0;
    hall = 1'b0;
    step(4);
    rd_chk(`PMIU_REG_IFLAG, 8'h00);
    $display("test edges finished");
    acc(1'b1, `PMIU_REG_IMASK, bit_of(`PMIU_B_WAKE));
    acc(1'b1, `PMIU_REG_SYSCTL, bit_of(`PMIU_C_POWER_STAGE_ON) | bit_of(`PMIU_C_STOP));
    wait_mode(PMIU_STOP);
    check({6'h00, recess, stages}, 8'h02);
    irq_base = irq_count;
    ana = '1;
    step(4);
    ana = '0;
    wake = 1'b0;
    step(4);
    irq_chk(8'h01);
    wait_mode(PMIU_NORMAL);
    rd_chk(`PMIU_REG_IFLAG, bit_of(`PMIU_B_WAKE));
    $display("test stop finished");
    acc(1'b1, `PMIU_REG_SYSCTL, bit_of(`PMIU_C_POWER_STAGE_ON) | bit_of(`PMIU_C_SLEEP));
    wait_mode(PMIU_SLEEP);
    check({6'h00, rst_n, vdd_on}, 8'h00);
    check({6'h00, recess, wd_run}, 8'h02);
    bus_dom = 1'b1;
    step(30010);
    bus_dom = 1'b0;
    wait_mode(PMIU_RESET);
    wait_mode(PMIU_NORMREQ);
    rd_chk(`PMIU_REG_RSTAT, bit_of(`PMIU_R_LINWK));
    rd_chk(`PMIU_REG_IMASK, 8'h00);
    wait_mode(PMIU_SLEEP);
    wake = 1'b1;
    wait_mode(PMIU_RESET);
    wait_mode(PMIU_NORMREQ);
    rd_chk(`PMIU_REG_RSTAT, 8'h03);
    $display("test sleep finished");
    give_verdict();
  end
endmodule : power_mode_and_interrupt_unit_test
`default_nettype wire
